// [bench/dfcs_term_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// terminal panel: levels move only on falling edges
// ----------------------------------------
module dfcs_term_model (
  // clock
  input wire logic clk_sys,
  // requested levels: terminals, then forward, then reverse
  input wire logic [9:0] want,
  // pins toward the drive
  output logic [7:0] terminal_pin,
  output logic forward_run_command,
  output logic reverse_run_command
);
  initial begin
    terminal_pin = 8'h00;
    forward_run_command = 1'b0;
    reverse_run_command = 1'b0;
  end
  // sampled one falling edge late, so the bench never races the panel
  always @(negedge clk_sys) begin
    terminal_pin <= want[7:0];
    forward_run_command <= want[8];
    reverse_run_command <= want[9];
  end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import dfcs_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [9:0] want = 10'h000;
  logic [7:0] terminal_pin;
  logic forward_run_command;
  logic reverse_run_command;
  dfcs_code_t [7:0] codes = {5'h00, FC_JOG_REV, FC_JOG_FWD, FC_JOG, FC_DC_BRAKE,
    FC_UD_CLEAR, FC_DOWN, FC_UP};
  logic [3:0] freq_method = 4'h0;
  logic [7:0] start_brake_level = START_BRAKE_LEVEL_DEF;
  logic [9:0] start_brake_time = 10'h000;
  dfcs_freq_t jog_frequency = JOG_FREQ_DEF;
  dfcs_freq_t base_reference = 16'h0BB8;
  logic [1:0] updown_mode_select = UD_MODE_STEP;
  dfcs_freq_t updown_step_frequency = UD_STEP_DEF;
  logic updown_save_select = 1'b1;
  logic limit_enable = 1'b0;
  dfcs_freq_t freq_command_reg;
  dfcs_freq_t updown_saved_frequency_reg;
  logic reverse_reg;
  logic running_reg;
  logic dc_brake_reg;
  logic [7:0] dc_brake_level_reg;
  int n_fail = 0;
  int checked = 0;
  int s;
  int k;
  int m_ref = 0;
  int m_saved = 0;
  logic [31:0] seed = 32'h79C2;

  always #20 clk_sys = ~clk_sys;

  dfcs_term_model dfcs_term_model_i (.clk_sys(clk_sys), .want(want),
    .terminal_pin(terminal_pin), .forward_run_command(forward_run_command),
    .reverse_run_command(reverse_run_command));

  // short tick keeps the 3 s hold near 3000 cycles
  dfcs_top #(.TICK_CYCLES(10)) dfcs_top_i (.clk_sys(clk_sys), .reset(reset),
    .terminal_pin(terminal_pin), .forward_run_command(forward_run_command),
    .reverse_run_command(reverse_run_command), .input_function_code(codes),
    .freq_method(freq_method), .start_brake_level(start_brake_level),
    .start_brake_time(start_brake_time), .jog_frequency(jog_frequency),
    .maximum_frequency(MAX_FREQ_DEF), .start_frequency(16'h0032),
    .limit_enable(limit_enable), .high_limit(16'h07D0), .low_limit(16'h01F4),
    .base_reference(base_reference), .ramp_step(16'h0064),
    .updown_save_select(updown_save_select), .updown_mode_select(updown_mode_select),
    .updown_step_frequency(updown_step_frequency), .freq_command_reg(freq_command_reg),
    .reverse_reg(reverse_reg), .running_reg(running_reg), .dc_brake_reg(dc_brake_reg),
    .dc_brake_level_reg(dc_brake_level_reg),
    .updown_saved_frequency_reg(updown_saved_frequency_reg));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input int exp);
    checked++;
    if (seen !== 16'(exp)) begin
      n_fail++;
      $display("wrong value at %0t: saw %0d expected %0d", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wait_freq(input int exp);
    int i;
    for (i = 0; i < 8000 && freq_command_reg !== 16'(exp); i++) cyc(1);
    chk(freq_command_reg, exp);
    if (i == 8000) report_and_stop();
  endtask

  task automatic pulse(input int p);
    want[p] <= 1'b1;
    cyc(4);
    want[p] <= 1'b0;
    cyc(1);
  endtask

  task automatic stop_run();
    want <= 10'h000;
    wait_freq(0);
    cyc(5);
  endtask

  // one up, down or clear pulse, then compare against the model once the ramp has settled
  task automatic ud(input int p, input int d, input bit sv);
    pulse(p);
    m_ref += d;
    if (sv) m_saved = m_ref;
    cyc(400);
    chk(freq_command_reg, m_ref);
    chk(updown_saved_frequency_reg, m_saved);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    seed = lfsr(seed);
    s = 200 + int'(seed % 32'd600);
    updown_step_frequency = 16'(s);
    cyc(5);
    start_brake_time = 10'h001;
    want <= 10'h100;
    for (k = 0; k < 20 && dc_brake_reg !== 1'b1; k++) cyc(1);
    chk(dc_brake_level_reg, 50);
    for (k = 0; k < 200 && running_reg !== 1'b1; k++) cyc(1);
    chk(16'(k >= 85 && k <= 105), 1);
    wait_freq(3000);
    stop_run();
    for (k = 0; k < 2; k++) begin
      start_brake_level = k ? 8'h32 : 8'h00;
      start_brake_time = k ? 10'h000 : 10'h001;
      want <= 10'h100;
      cyc(8);
      chk(16'({running_reg, dc_brake_reg}), 2);
      stop_run();
    end
    base_reference = 16'h0014;
    want <= 10'h100;
    cyc(60);
    chk(freq_command_reg, 0);
    base_reference = 16'h1B58;
    wait_freq(6000);
    base_reference = 16'h0BB8;
    jog_frequency = 16'h1964;
    want <= 10'h110;
    wait_freq(3000);
    jog_frequency = JOG_FREQ_DEF;
    wait_freq(1000);
    stop_run();
    want <= 10'h008;
    cyc(8);
    chk(16'({dc_brake_reg, dc_brake_level_reg}), 16'h0132);
    want <= 10'h000;
    cyc(5);
    for (k = 5; k < 7; k++) begin
      want <= 10'(1 << k);
      wait_freq(1000);
      chk(16'(reverse_reg), k - 5);
      stop_run();
    end
    freq_method = FRQ_METHOD_UPDOWN;
    want <= 10'h110;
    wait_freq(1000);
    want <= 10'h100;
    wait_freq(0);
    pulse(0);
    ud(0, s, 1);
    want <= 10'h105;
    cyc(5);
    want <= 10'h101;
    cyc(400);
    chk(updown_saved_frequency_reg, m_saved);
    ud(0, s, 1);
    ud(1, -s, 1);
    m_saved = 0;
    ud(2, 0, 0);
    chk(updown_saved_frequency_reg, m_saved);
    updown_save_select = 1'b0;
    ud(0, s, 0);
    updown_save_select = 1'b1;
    stop_run();
    chk(updown_saved_frequency_reg, m_saved);
    limit_enable = 1'b1;
    updown_mode_select = UD_MODE_RAMP;
    want <= 10'h101;
    wait_freq(2000);
    want <= 10'h102;
    wait_freq(500);
    want <= 10'h100;
    updown_mode_select = UD_MODE_COMBO;
    cyc(5);
    want <= 10'h101;
    cyc(1500);
    chk(freq_command_reg, 500 + s);
    wait_freq(2000);
    want <= 10'h100;
    freq_method = 4'h0;
    wait_freq(3000);
    want <= 10'h101;
    cyc(300);
    chk(freq_command_reg, 3000);
    stop_run();
    report_and_stop();
  end
endmodule

// [hw/dfcs_tick.sv]
`timescale 1ns/1ps
module dfcs_tick #(
  parameter int TICK_CYCLES = 250000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // tick out
  dfcs_tick_if.src tif
);
  logic [17:0] cnt_reg;
  logic tick_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_reg <= 18'h00000;
      tick_reg <= 1'b0;
    end else if (cnt_reg == 18'(TICK_CYCLES - 1)) begin
      cnt_reg <= 18'h00000;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 18'h00001;
      tick_reg <= 1'b0;
    end
  end

  assign tif.tick = tick_reg;
endmodule

// [hw/dfcs_top.sv]
// Notes on behaviour
// - start brake level is a percent of rated current, 0..200, default 50.
// - at start, hold dc brake for the start brake time, then accelerate.
// - zero level or zero time skips the start brake phase.
// - terminal code 11 brakes with the start level while stopped.
// - terminal code 4 runs at the jog frequency, 0..400 Hz, default 10 Hz.
// - jog frequency only accepted between start and maximum frequency.
// - jog overrides multi-step, up-down and 3-wire references.
// - up-down works only with frequency method 8.
// - code 15 up, 16 down, 25 clears the saved up-down frequency.
// - save select 1 stores the frequency before stop; 0 stores nothing.
// - clear input wipes the saved frequency while saving is enabled.
// - clear is ignored while up or down is held.
// - mode 0 ramps up to upper limit, down to lower limit, while held.
// - mode 1 steps per edge, saves at release, never ramps.
// - mode 1 stop keeps the last release value, never the present one.
// - mode 2 steps per edge, ramps continuously after 3 s held.
// - edge during an unfinished step is ignored; save at release.
// - step 0..400 Hz default 0; mode select 0..2 default 0.
// - below start frequency becomes zero; never above maximum.
`timescale 1ns/1ps
module dfcs_top
  import dfcs_pkg::*;
#(
  parameter int TICK_CYCLES = dfcs_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // terminal pins
  input wire logic [7:0] terminal_pin,
  input wire logic forward_run_command,
  input wire logic reverse_run_command,
  // configuration
  input wire dfcs_pkg::dfcs_code_t [7:0] input_function_code,
  input wire logic [3:0] freq_method,
  input wire logic [7:0] start_brake_level,
  input wire logic [9:0] start_brake_time,
  input wire dfcs_pkg::dfcs_freq_t jog_frequency,
  input wire dfcs_pkg::dfcs_freq_t maximum_frequency,
  input wire dfcs_pkg::dfcs_freq_t start_frequency,
  input wire logic limit_enable,
  input wire dfcs_pkg::dfcs_freq_t high_limit,
  input wire dfcs_pkg::dfcs_freq_t low_limit,
  input wire dfcs_pkg::dfcs_freq_t base_reference,
  input wire dfcs_pkg::dfcs_freq_t ramp_step,
  input wire logic updown_save_select,
  input wire logic [1:0] updown_mode_select,
  input wire dfcs_pkg::dfcs_freq_t updown_step_frequency,
  // drive stage commands
  output dfcs_pkg::dfcs_freq_t freq_command_reg,
  output logic reverse_reg,
  output logic running_reg,
  output logic dc_brake_reg,
  output logic [7:0] dc_brake_level_reg,
  // saved up-down frequency
  output dfcs_pkg::dfcs_freq_t updown_saved_frequency_reg
);
  import dfcs_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [9:0] pin_meta_reg;
  logic [9:0] pin_sync_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_meta_reg <= 10'h000;
      pin_sync_reg <= 10'h000;
    end else begin
      pin_meta_reg <= {reverse_run_command, forward_run_command, terminal_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  dfcs_tick_if tif ();
  dfcs_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .tif(tif)
  );
  logic tick;
  assign tick = tif.tick;

  // ----------------------------------------
  // terminal decode
  // ----------------------------------------
  logic [7:0] term;
  logic [7:0] jog_hit, jogf_hit, jogr_hit, dcb_hit, up_hit, dn_hit, clr_hit;
  assign term = pin_sync_reg[7:0];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_term
      assign up_hit[gi] = term[gi] && (input_function_code[gi] == FC_UP);
      assign dn_hit[gi] = term[gi] && (input_function_code[gi] == FC_DOWN);
      assign clr_hit[gi] = term[gi] && (input_function_code[gi] == FC_UD_CLEAR);
      assign jog_hit[gi] = term[gi] && (input_function_code[gi] == FC_JOG);
      assign jogf_hit[gi] = term[gi] && (input_function_code[gi] == FC_JOG_FWD);
      assign jogr_hit[gi] = term[gi] && (input_function_code[gi] == FC_JOG_REV);
      assign dcb_hit[gi] = term[gi] && (input_function_code[gi] == FC_DC_BRAKE);
    end
  endgenerate

  logic updown_on, up_act, dn_act, clr_act, jog_ok, jog_req, run_req, dir_rev;
  assign updown_on = (freq_method == FRQ_METHOD_UPDOWN);
  assign up_act = updown_on && (|up_hit);
  assign dn_act = updown_on && (|dn_hit);
  assign clr_act = updown_on && (|clr_hit);
  assign jog_ok = (jog_frequency >= start_frequency) && (jog_frequency <= maximum_frequency);
  assign jog_req = jog_ok && ((|jog_hit) || (|jogf_hit) || (|jogr_hit));
  assign run_req = jog_req || pin_sync_reg[8] || pin_sync_reg[9];
  assign dir_rev = jog_req ? (|jogr_hit) : (pin_sync_reg[9] && !pin_sync_reg[8]);

  // ----------------------------------------
  // run sequencer
  // ----------------------------------------
  dfcs_state_t state_reg;
  logic [15:0] brake_cnt_reg;
  logic [15:0] brake_goal;
  logic brake_skip;
  assign brake_goal = 16'(start_brake_time) * 16'(BRAKE_TICKS_PER_UNIT);
  assign brake_skip = (start_brake_level == 8'h00) || (start_brake_time == 10'h000);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      brake_cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          brake_cnt_reg <= 16'h0000;
          if (run_req && brake_skip) begin
            state_reg <= ST_RUN;
          end else if (run_req) begin
            state_reg <= ST_START_BRAKE;
          end
        end
        ST_START_BRAKE: begin
          if (!run_req) begin
            state_reg <= ST_IDLE;
          end else if (tick) begin
            brake_cnt_reg <= brake_cnt_reg + 16'h0001;
            if (brake_cnt_reg + 16'h0001 >= brake_goal) begin
              state_reg <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (!run_req) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // up-down reference
  // ----------------------------------------
  function automatic dfcs_freq_t sat_add(dfcs_freq_t a, dfcs_freq_t b, dfcs_freq_t lim);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > {1'b0, lim}) ? lim : s[15:0];
  endfunction

  function automatic dfcs_freq_t sat_sub(dfcs_freq_t a, dfcs_freq_t b, dfcs_freq_t lim);
    logic [16:0] s;
    s = {1'b0, lim} + {1'b0, b};
    return ({1'b0, a} < s) ? lim : (a - b);
  endfunction

  dfcs_freq_t ud_ref_reg;
  logic up_prev_reg, dn_prev_reg, clr_prev_reg;
  logic [8:0] hold_cnt_reg;
  dfcs_freq_t upper, lower;
  logic up_rise, dn_rise, ud_fall, step_busy, ramp_on, run_stop, save_evt, clr_evt;

  assign upper = limit_enable ? high_limit : maximum_frequency;
  assign lower = limit_enable ? low_limit : 16'h0000;
  assign up_rise = up_act && !up_prev_reg;
  assign dn_rise = dn_act && !dn_prev_reg;
  assign ud_fall = (up_prev_reg && !up_act) || (dn_prev_reg && !dn_act);
  // the output ramp is the only measure of step completion
  assign step_busy = (freq_command_reg != ud_ref_reg);
  assign ramp_on = (updown_mode_select == UD_MODE_RAMP) ||
                   ((updown_mode_select == UD_MODE_COMBO) && (hold_cnt_reg == HOLD_TICKS));
  assign run_stop = (state_reg == ST_RUN) && !run_req;
  // mode 1 stop keeps release value
  assign save_evt = updown_on && updown_save_select &&
                    (ud_fall || (run_stop && (updown_mode_select == UD_MODE_RAMP)));
  assign clr_evt = clr_act && !clr_prev_reg && updown_save_select && !up_act && !dn_act;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      up_prev_reg <= 1'b0;
      dn_prev_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
      hold_cnt_reg <= 9'h000;
    end else begin
      up_prev_reg <= up_act;
      dn_prev_reg <= dn_act;
      clr_prev_reg <= clr_act;
      if (up_act == dn_act) begin
        hold_cnt_reg <= 9'h000;
      end else if (tick && hold_cnt_reg < HOLD_TICKS) begin
        hold_cnt_reg <= hold_cnt_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ud_ref_reg <= 16'h0000;
    end else if (state_reg == ST_IDLE && run_req && updown_save_select) begin
      ud_ref_reg <= updown_saved_frequency_reg;
    end else if (updown_on && ramp_on) begin
      if (tick && up_act && !dn_act) begin
        ud_ref_reg <= sat_add(ud_ref_reg, ramp_step, upper);
      end else if (tick && dn_act && !up_act) begin
        ud_ref_reg <= sat_sub(ud_ref_reg, ramp_step, lower);
      end
    end else if (updown_on && !step_busy) begin
      if (up_rise) begin
        ud_ref_reg <= sat_add(ud_ref_reg, updown_step_frequency, upper);
      end else if (dn_rise) begin
        ud_ref_reg <= sat_sub(ud_ref_reg, updown_step_frequency, lower);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      updown_saved_frequency_reg <= 16'h0000;
    end else if (save_evt) begin
      // save at release, set beats clear
      updown_saved_frequency_reg <= ud_ref_reg;
    end else if (clr_evt) begin
      updown_saved_frequency_reg <= 16'h0000;
    end
  end

  // ----------------------------------------
  // reference select and output ramp
  // ----------------------------------------
  dfcs_freq_t ref_sel, target;
  assign ref_sel = jog_req ? jog_frequency : (updown_on ? ud_ref_reg : base_reference);
  always_comb begin
    target = 16'h0000;
    if (state_reg == ST_RUN && run_req) begin
      if (ref_sel > maximum_frequency) begin
        target = maximum_frequency;
      end else if (ref_sel >= start_frequency) begin
        target = ref_sel;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      freq_command_reg <= 16'h0000;
    end else if (ramp_step == 16'h0000) begin
      freq_command_reg <= target;
    end else if (tick && freq_command_reg < target) begin
      freq_command_reg <= sat_add(freq_command_reg, ramp_step, target);
    end else if (tick && freq_command_reg > target) begin
      freq_command_reg <= sat_sub(freq_command_reg, ramp_step, target);
    end
  end

  // ----------------------------------------
  // brake and direction outputs
  // ----------------------------------------
  logic brake_on;
  assign brake_on = (state_reg == ST_START_BRAKE) ||
                    (state_reg == ST_IDLE && !run_req && (|dcb_hit));
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dc_brake_reg <= 1'b0;
      dc_brake_level_reg <= 8'h00;
      reverse_reg <= 1'b0;
      running_reg <= 1'b0;
    end else begin
      dc_brake_reg <= brake_on;
      dc_brake_level_reg <= brake_on ? start_brake_level : 8'h00;
      reverse_reg <= run_req ? dir_rev : reverse_reg;
      running_reg <= (state_reg == ST_RUN);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_brake_level;
    state_reg == ST_START_BRAKE |=> dc_brake_reg && dc_brake_level_reg == $past(start_brake_level);
  endproperty
  a_brake_level: assert property (p_brake_level) else $error("start brake level wrong");

  property p_brake_hold;
    state_reg == ST_START_BRAKE && run_req && !(tick && brake_cnt_reg + 16'h0001 >= brake_goal)
      |=> state_reg == ST_START_BRAKE;
  endproperty
  a_brake_hold: assert property (p_brake_hold) else $error("brake left early");

  property p_brake_skip;
    state_reg == ST_IDLE && run_req && brake_skip |=> state_reg == ST_RUN;
  endproperty
  a_brake_skip: assert property (p_brake_skip) else $error("zero brake not skipped");

  property p_stop_brake;
    state_reg == ST_IDLE && !run_req && (|dcb_hit) |=> dc_brake_reg;
  endproperty
  a_stop_brake: assert property (p_stop_brake) else $error("stopped brake missing");

  property p_jog_first;
    jog_req && state_reg == ST_RUN |-> target == jog_frequency;
  endproperty
  a_jog_first: assert property (p_jog_first) else $error("jog not selected");

  property p_clamp;
    target <= maximum_frequency && (target == 16'h0000 || target >= start_frequency);
  endproperty
  a_clamp: assert property (p_clamp) else $error("target out of range");

  property p_clear;
    clr_evt && !save_evt |=> updown_saved_frequency_reg == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("saved frequency not cleared");

  property p_busy_drop;
    updown_on && !ramp_on && step_busy && up_rise && !(state_reg == ST_IDLE && run_req)
      |=> $stable(ud_ref_reg);
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("edge taken while busy");

  property p_combo_ramp;
    updown_on && updown_mode_select == UD_MODE_COMBO && hold_cnt_reg < HOLD_TICKS &&
      !step_busy && !up_rise && !dn_rise && !(state_reg == ST_IDLE && run_req)
      |=> $stable(ud_ref_reg);
  endproperty
  a_combo_ramp: assert property (p_combo_ramp) else $error("ramp before hold time");
endmodule

// [inc/dfcs_pkg.sv]
package dfcs_pkg;
  // ----------------------------------------
  // data types
  // ----------------------------------------
  typedef logic [15:0] dfcs_freq_t;
  typedef logic [4:0] dfcs_code_t;

  typedef enum logic [1:0] {
    ST_IDLE        = 2'b00,
    ST_START_BRAKE = 2'b01,
    ST_RUN         = 2'b10
  } dfcs_state_t;

  // ----------------------------------------
  // terminal function codes
  // ----------------------------------------
  localparam dfcs_code_t FC_JOG = 5'h04;
  localparam dfcs_code_t FC_DC_BRAKE = 5'h0B;
  localparam dfcs_code_t FC_UP = 5'h0F;
  localparam dfcs_code_t FC_DOWN = 5'h10;
  localparam dfcs_code_t FC_UD_CLEAR = 5'h19;
  localparam dfcs_code_t FC_JOG_FWD = 5'h1A;
  localparam dfcs_code_t FC_JOG_REV = 5'h1B;

  localparam logic [3:0] FRQ_METHOD_UPDOWN = 4'h8;
  localparam logic [1:0] UD_MODE_RAMP = 2'h0;
  localparam logic [1:0] UD_MODE_STEP = 2'h1;
  localparam logic [1:0] UD_MODE_COMBO = 2'h2;

  // ----------------------------------------
  // documented defaults (0.01 Hz, percent)
  // ----------------------------------------
  localparam logic [7:0] START_BRAKE_LEVEL_DEF = 8'h32;
  localparam dfcs_freq_t JOG_FREQ_DEF = 16'h03E8;
  localparam dfcs_freq_t MAX_FREQ_DEF = 16'h1770;
  localparam dfcs_freq_t UD_STEP_DEF = 16'h0000;

  // ----------------------------------------
  // time base
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TICK_PERIOD_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int BRAKE_UNIT_MS = 100;
  localparam logic [5:0] BRAKE_TICKS_PER_UNIT = 6'(BRAKE_UNIT_MS / TICK_PERIOD_MS);
  localparam int HOLD_TIME_MS = 3000;
  localparam logic [8:0] HOLD_TICKS = 9'(HOLD_TIME_MS / TICK_PERIOD_MS);
endpackage

// [inc/dfcs_tick_if.sv]
`timescale 1ns/1ps
interface dfcs_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface
